// ===== logic/pispc_top.sv
// How it works
// - Deviation is setpoint minus feedback, steering output frequency to shrink it.
// - Proportional term is deviation times proportional gain, linear and direct.
// - Integral term is the accumulated deviation, removing the steady offset.
// - Integral time constant scales the integral; shorter means faster.
// - Modes 1 and 2 take a dedicated setpoint, else the frequency reference.
// - Modes 3 and 4 take the setpoint from dedicated sources only.
// - An analogue input with function code C supplies the setpoint.
// - Master sets command bit 1 and writes setpoint word; device uses it.
// - Stored setpoint enable at 1 selects the stored setpoint value.
// - Setpoint assigned to several sources raises the configuration error alarm.
// - Primary feedback comes from the analogue input with code B.
// - Primary feedback assigned twice raises the configuration error alarm.
// - Differential feedback comes from the analogue input with code 16.
// - Differential operation turns on whenever an input carries code 16.
// - Differential feedback assigned twice raises the configuration error alarm.
// - Mode 1 makes the controller output the frequency reference.
// - Mode 3 adds controller output to the ordinary frequency reference.
// - Integral time zero switches the integral path off.
`include "pispc_regs.svh"

module pispc_top #(
    parameter int SAMPLE_CYCLES = `PISPC_SAMPLE_CYCLES,
    parameter int SAMPLES_PER_TI_UNIT = `PISPC_SAMPLES_PER_TI_UNIT
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire pispc_pkg::pispc_reg_req_t reg_req_in,
    output logic [15:0] reg_rdata_out,
    input wire logic [2:0] controller_function_mode_in,
    input wire pispc_pkg::pispc_ain_t analog_input_one_in,
    input wire pispc_pkg::pispc_ain_t analog_input_two_in,
    input wire logic stored_setpoint_enable_in,
    input wire logic signed [15:0] stored_setpoint_value_in,
    input wire logic [15:0] prop_gain_in,
    input wire logic [15:0] integral_time_setting_in,
    input wire logic signed [15:0] freq_ref_in,
    output logic signed [15:0] freq_out_out,
    output logic signed [15:0] pi_output_out,
    output logic signed [15:0] deviation_out,
    output logic config_error_alarm_out,
    output logic diff_feedback_active_out,
    output logic sample_done_out
);

    localparam logic [31:0] SAMPLE_LAST = 32'(SAMPLE_CYCLES - 1);
    localparam int NUM_AIN = 2;

    pispc_pkg::pispc_top_state_t s_r;
    pispc_pkg::pispc_top_state_t s_nxt;

    pispc_pkg::pispc_ain_t ain [NUM_AIN];
    logic [NUM_AIN-1:0] is_sp;
    logic [NUM_AIN-1:0] is_fb;
    logic [NUM_AIN-1:0] is_dfb;

    logic modbus_sp_sel;
    logic stored_sp_sel;
    logic [2:0] sp_count;
    logic sp_dup;
    logic fb_dup;
    logic dfb_dup;
    logic dfb_on;
    logic mode_build;
    logic mode_trim;
    logic pi_enabled;
    logic integ_clear;

    logic signed [15:0] setpoint;
    logic signed [15:0] fb_primary;
    logic signed [15:0] fb_diff;
    logic signed [15:0] fb_eff;
    logic signed [16:0] fb_sub;
    logic signed [16:0] dev_sub;
    logic signed [32:0] p_prod;
    logic signed [16:0] pi_sum;
    logic signed [16:0] trim_sum;

    logic int_done;
    logic signed [15:0] int_val;

    function automatic logic signed [15:0] sat16(input logic signed [32:0] v);
        if (v > 33'sh0_0000_7fff) begin
            sat16 = 16'sh7fff;
        end else if (v < -33'sh0_0000_7fff) begin
            sat16 = 16'sh8001;
        end else begin
            sat16 = v[15:0];
        end
    endfunction

    // ----------------------------------------
    // Per-input function decode
    // ----------------------------------------
    assign ain[0] = analog_input_one_in;
    assign ain[1] = analog_input_two_in;

    for (genvar g = 0; g < NUM_AIN; g++) begin : g_ain
        assign is_sp[g] = (ain[g].function_select == `PISPC_FUNC_SETPOINT);
        assign is_fb[g] = (ain[g].function_select == `PISPC_FUNC_FEEDBACK);
        assign is_dfb[g] = (ain[g].function_select == `PISPC_FUNC_DIFF_FB);
    end

    // ----------------------------------------
    // Source selection and allocation checks
    // ----------------------------------------
    assign modbus_sp_sel = s_r.cmd_sel[`PISPC_CMD_SEL_SP_BIT];
    assign stored_sp_sel = stored_setpoint_enable_in;
    assign sp_count = 3'(is_sp[0]) + 3'(is_sp[1]) + 3'(modbus_sp_sel) + 3'(stored_sp_sel);
    assign sp_dup = (sp_count > 3'h1);
    assign fb_dup = &is_fb;
    assign dfb_dup = &is_dfb;
    // No enable of its own: assigning the code is the switch
    assign dfb_on = |is_dfb;

    assign mode_build = (controller_function_mode_in == `PISPC_MODE_BUILD_1) ||
                        (controller_function_mode_in == `PISPC_MODE_BUILD_2);
    assign mode_trim = (controller_function_mode_in == `PISPC_MODE_TRIM_3) ||
                       (controller_function_mode_in == `PISPC_MODE_TRIM_4);
    assign pi_enabled = (mode_build || mode_trim) && !s_r.cfg_err;
    // Cleared while off so re-enabling never starts from stale windup
    assign integ_clear = !pi_enabled || (integral_time_setting_in == 16'h0000);

    always_comb begin
        if (is_sp[0]) begin
            setpoint = ain[0].sample;
        end else if (is_sp[1]) begin
            setpoint = ain[1].sample;
        end else if (modbus_sp_sel) begin
            setpoint = $signed(s_r.setpoint_word);
        end else if (stored_sp_sel) begin
            setpoint = stored_setpoint_value_in;
        end else if (mode_build) begin
            setpoint = freq_ref_in;
        end else begin
            // Trim modes have no fallback source
            setpoint = 16'sh0000;
        end
    end

    always_comb begin
        if (is_fb[0]) begin
            fb_primary = ain[0].sample;
        end else if (is_fb[1]) begin
            fb_primary = ain[1].sample;
        end else begin
            fb_primary = 16'sh0000;
        end
        if (is_dfb[0]) begin
            fb_diff = ain[0].sample;
        end else if (is_dfb[1]) begin
            fb_diff = ain[1].sample;
        end else begin
            fb_diff = 16'sh0000;
        end
    end

    // ----------------------------------------
    // Arithmetic
    // ----------------------------------------
    assign fb_sub = 17'(fb_primary) - 17'(fb_diff);
    assign fb_eff = dfb_on ? sat16(33'(fb_sub)) : fb_primary;
    assign dev_sub = 17'(setpoint) - 17'(fb_eff);
    assign p_prod = s_r.dev * $signed({1'b0, prop_gain_in});
    assign pi_sum = 17'(s_r.p_term) + 17'(int_val);
    assign trim_sum = 17'(freq_ref_in) + 17'(s_r.pi_out);

    // ----------------------------------------
    // Integral path
    // ----------------------------------------
    pispc_integrator #(
        .SAMPLES_PER_TI_UNIT(SAMPLES_PER_TI_UNIT)
    ) u_integ (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .start_in(s_r.int_start),
        .clear_in(integ_clear),
        .dev_in(s_r.dev),
        .ti_in(integral_time_setting_in),
        .done_out(int_done),
        .integ_out(int_val)
    );

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.int_start = 1'b0;
        s_nxt.sample_done = 1'b0;
        s_nxt.cfg_err = sp_dup || fb_dup || dfb_dup;
        s_nxt.diff_active = dfb_on;

        // Register port: plain write, read answered next cycle
        if (reg_req_in.wr_en) begin
            if (reg_req_in.addr == `PISPC_SETPOINT_WORD_OFS) begin
                s_nxt.setpoint_word = reg_req_in.wdata;
            end else if (reg_req_in.addr == `PISPC_CMD_SEL_OFS) begin
                s_nxt.cmd_sel = reg_req_in.wdata;
            end
        end
        if (reg_req_in.rd_en) begin
            if (reg_req_in.addr == `PISPC_SETPOINT_WORD_OFS) begin
                s_nxt.rdata = s_r.setpoint_word;
            end else if (reg_req_in.addr == `PISPC_CMD_SEL_OFS) begin
                s_nxt.rdata = s_r.cmd_sel;
            end else begin
                s_nxt.rdata = 16'h0000;
            end
        end

        // Sample timebase free-runs so the rate never depends on mode
        if (s_r.sample_cnt >= SAMPLE_LAST) begin
            s_nxt.sample_cnt = '0;
        end else begin
            s_nxt.sample_cnt = s_r.sample_cnt + 32'h1;
        end

        unique case (s_r.state)
            pispc_pkg::PISPC_ST_IDLE: begin
                if (s_r.sample_cnt >= SAMPLE_LAST) begin
                    s_nxt.dev = sat16(33'(dev_sub));
                    s_nxt.int_start = 1'b1;
                    s_nxt.state = pispc_pkg::PISPC_ST_INTEG;
                end
            end
            pispc_pkg::PISPC_ST_INTEG: begin
                s_nxt.p_term = sat16(p_prod >>> `PISPC_GAIN_FRAC_BITS);
                if (int_done) begin
                    s_nxt.state = pispc_pkg::PISPC_ST_OUTPUT;
                end
            end
            pispc_pkg::PISPC_ST_OUTPUT: begin
                if (pi_enabled) begin
                    s_nxt.pi_out = sat16(33'(pi_sum));
                end else begin
                    s_nxt.pi_out = 16'sh0000;
                end
                s_nxt.state = pispc_pkg::PISPC_ST_IDLE;
                s_nxt.sample_done = 1'b1;
            end
        endcase

        // Output frequency is the latest controller result in modes 1 and 2, the reference plus that result in modes 3 and 4, else the frequency reference
        if (pi_enabled && mode_build) begin
            s_nxt.freq_out = s_r.pi_out;
        end else if (pi_enabled && mode_trim) begin
            s_nxt.freq_out = sat16(33'(trim_sum));
        end else begin
            s_nxt.freq_out = freq_ref_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            s_r <= '0;
            s_r.state <= pispc_pkg::PISPC_ST_IDLE;
            s_r.setpoint_word <= `PISPC_SETPOINT_WORD_RST;
            s_r.cmd_sel <= `PISPC_CMD_SEL_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign reg_rdata_out = s_r.rdata;
    assign freq_out_out = s_r.freq_out;
    assign pi_output_out = s_r.pi_out;
    assign deviation_out = s_r.dev;
    assign config_error_alarm_out = s_r.cfg_err;
    assign diff_feedback_active_out = s_r.diff_active;
    assign sample_done_out = s_r.sample_done;

endmodule // pispc_top

// ===== logic/pispc_regs.svh
`ifndef PISPC_REGS_SVH
`define PISPC_REGS_SVH

// ----------------------------------------
// Register offsets and fields
// ----------------------------------------
`define PISPC_SETPOINT_WORD_OFS 16'h0006
`define PISPC_CMD_SEL_OFS 16'h000f
`define PISPC_CMD_SEL_SP_BIT 1
`define PISPC_SETPOINT_WORD_RST 16'h0000
`define PISPC_CMD_SEL_RST 16'h0000

// ----------------------------------------
// Function codes and modes
// ----------------------------------------
`define PISPC_FUNC_SETPOINT 8'h0c
`define PISPC_FUNC_FEEDBACK 8'h0b
`define PISPC_FUNC_DIFF_FB 8'h16
`define PISPC_MODE_OFF 3'h0
`define PISPC_MODE_BUILD_1 3'h1
`define PISPC_MODE_BUILD_2 3'h2
`define PISPC_MODE_TRIM_3 3'h3
`define PISPC_MODE_TRIM_4 3'h4
`define PISPC_GAIN_FRAC_BITS 8

// ----------------------------------------
// Timing
// ----------------------------------------
`define PISPC_CLK_NS 20
`define PISPC_SAMPLE_NS 1000000
`define PISPC_TI_UNIT_NS 100000000
`define PISPC_SAMPLE_CYCLES (`PISPC_SAMPLE_NS / `PISPC_CLK_NS)
`define PISPC_SAMPLES_PER_TI_UNIT (`PISPC_TI_UNIT_NS / `PISPC_SAMPLE_NS)

`endif

// ===== logic/pispc_pkg.sv
package pispc_pkg;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] function_select;
        logic signed [15:0] sample;
    } pispc_ain_t;

    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [15:0] addr;
        logic [15:0] wdata;
    } pispc_reg_req_t;

    // ----------------------------------------
    // Sequencer states
    // ----------------------------------------
    typedef enum logic [1:0] {
        PISPC_ST_IDLE,
        PISPC_ST_INTEG,
        PISPC_ST_OUTPUT
    } pispc_state_t;

    typedef struct packed {
        pispc_state_t state;
        logic [31:0] sample_cnt;
        logic [15:0] setpoint_word;
        logic [15:0] cmd_sel;
        logic [15:0] rdata;
        logic signed [15:0] dev;
        logic signed [15:0] p_term;
        logic signed [15:0] pi_out;
        logic signed [15:0] freq_out;
        logic int_start;
        logic cfg_err;
        logic diff_active;
        logic sample_done;
    } pispc_top_state_t;

    typedef struct packed {
        logic signed [39:0] acc;
        logic [39:0] dq;
        logic [32:0] rem;
        logic [5:0] steps;
        logic busy;
        logic neg;
        logic done;
        logic signed [15:0] integ;
    } pispc_int_state_t;

endpackage

// ===== logic/pispc_integrator.sv
`include "pispc_regs.svh"

module pispc_integrator #(
    parameter int SAMPLES_PER_TI_UNIT = `PISPC_SAMPLES_PER_TI_UNIT
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic start_in,
    input wire logic clear_in,
    input wire logic signed [15:0] dev_in,
    input wire logic [15:0] ti_in,
    output logic done_out,
    output logic signed [15:0] integ_out
);

    localparam int DQ_W = 40;
    localparam logic [15:0] STEPS_PER_UNIT = 16'(SAMPLES_PER_TI_UNIT);

    pispc_pkg::pispc_int_state_t s_r;
    pispc_pkg::pispc_int_state_t s_nxt;

    logic signed [40:0] acc_sum;
    logic [31:0] divisor;
    logic [32:0] rem_sh;
    logic [39:0] acc_mag;

    // ----------------------------------------
    // Accumulate, then scale by the time constant
    // ----------------------------------------
    // Sum of deviations divided by Ti in samples: shorter Ti, faster rise
    assign divisor = ti_in * STEPS_PER_UNIT;
    assign acc_sum = 41'(s_r.acc) + 41'(dev_in);
    assign rem_sh = {s_r.rem[31:0], s_r.dq[DQ_W-1]};
    assign acc_mag = s_r.acc[39] ? 40'(-s_r.acc) : 40'(s_r.acc);

    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        if (clear_in) begin
            // Integral path off: nothing held, answers zero at once
            s_nxt.acc = '0;
            s_nxt.busy = 1'b0;
            s_nxt.integ = '0;
            // Aborted division still answers, else the sequencer waits forever
            s_nxt.done = start_in || s_r.busy;
        end else if (start_in && !s_r.busy) begin
            // Saturate rather than wrap so a long offset cannot flip sign
            if (acc_sum[40] != acc_sum[39]) begin
                s_nxt.acc = acc_sum[40] ? {1'b1, 39'h0} : {1'b0, {39{1'b1}}};
            end else begin
                s_nxt.acc = acc_sum[39:0];
            end
            s_nxt.busy = 1'b1;
            s_nxt.steps = '0;
            s_nxt.rem = '0;
            s_nxt.neg = 1'b0;
        end else if (s_r.busy && s_r.steps == 6'h00 && s_r.rem == 33'h0 && !s_r.neg && s_r.dq == 40'h0
                     && s_r.acc != 40'h0) begin
            // Load magnitude of the fresh sum on the first busy cycle
            s_nxt.dq = acc_mag;
            s_nxt.neg = s_r.acc[39];
            s_nxt.steps = 6'h01;
        end else if (s_r.busy && s_r.steps < 6'(DQ_W + 1)) begin
            if (s_r.steps == 6'h00) begin
                s_nxt.dq = acc_mag;
                s_nxt.neg = s_r.acc[39];
                s_nxt.steps = 6'h01;
            end else if (rem_sh >= {1'b0, divisor}) begin
                s_nxt.rem = rem_sh - {1'b0, divisor};
                s_nxt.dq = {s_r.dq[DQ_W-2:0], 1'b1};
                s_nxt.steps = s_r.steps + 6'h01;
            end else begin
                s_nxt.rem = rem_sh;
                s_nxt.dq = {s_r.dq[DQ_W-2:0], 1'b0};
                s_nxt.steps = s_r.steps + 6'h01;
            end
        end else if (s_r.busy) begin
            s_nxt.busy = 1'b0;
            s_nxt.done = 1'b1;
            if (|s_r.dq[39:15]) begin
                s_nxt.integ = s_r.neg ? 16'sh8001 : 16'sh7fff;
            end else begin
                s_nxt.integ = s_r.neg ? -$signed({1'b0, s_r.dq[14:0]}) : $signed({1'b0, s_r.dq[14:0]});
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign done_out = s_r.done;
    assign integ_out = s_r.integ;

endmodule // pispc_integrator

// ===== testbench/pispc_sensor_model.sv
module pispc_sensor_model (
    input wire logic clk_in,
    input wire logic [7:0] code_in,
    input wire logic signed [15:0] level_in,
    output pispc_pkg::pispc_ain_t ain_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Sensor output
    // ----------------------------------------
    // Settles between rising edges, so the design never samples a change
    always @(negedge clk_in) begin
        ain_out <= '{function_select: code_in, sample: level_in};
    end
endmodule // pispc_sensor_model

// ===== testbench/pispc_top_chk.sv
module pispc_top_chk (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire pispc_pkg::pispc_reg_req_t reg_req_in,
    input wire logic [15:0] reg_rdata_out,
    input wire logic [2:0] controller_function_mode_in,
    input wire pispc_pkg::pispc_ain_t analog_input_one_in,
    input wire pispc_pkg::pispc_ain_t analog_input_two_in,
    input wire logic [15:0] prop_gain_in,
    input wire logic [15:0] integral_time_setting_in,
    input wire logic signed [15:0] freq_ref_in,
    input wire logic signed [15:0] freq_out_out,
    input wire logic signed [15:0] pi_output_out,
    input wire logic signed [15:0] deviation_out,
    input wire logic config_error_alarm_out,
    input wire logic diff_feedback_active_out,
    input wire logic sample_done_out
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    logic [7:0] f1, f2;
    logic signed [32:0] prod;
    logic signed [16:0] trim;
    logic signed [15:0] p_sat, t_sat;
    assign f1 = analog_input_one_in.function_select;
    assign f2 = analog_input_two_in.function_select;
    assign prod = (deviation_out * $signed({1'b0, prop_gain_in})) >>> 8;
    // Only used for non-negative deviation, so no lower clamp
    assign p_sat = (prod > 33'sh7fff) ? 16'sh7fff : prod[15:0];
    assign trim = 17'(freq_ref_in) + 17'(pi_output_out);
    assign t_sat = (trim > 17'sh7fff) ? 16'sh7fff : (trim < -17'sh7fff) ? 16'sh8001 : trim[15:0];
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_done_pulse;
        sample_done_out |=> !sample_done_out;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("sample done too long");
    property p_dup;
        (f1 == f2) && (f1 inside {8'h0b, 8'h0c, 8'h16}) |=> config_error_alarm_out;
    endproperty
    a_dup: assert property (p_dup) else $error("duplicate source without alarm");
    property p_diff_on;
        (f1 == 8'h16) || (f2 == 8'h16) |=> diff_feedback_active_out;
    endproperty
    a_diff_on: assert property (p_diff_on) else $error("differential feedback not active");
    property p_build;
        sample_done_out && controller_function_mode_in == 3'h1 && !config_error_alarm_out
            |-> ##2 freq_out_out == $past(pi_output_out, 2);
    endproperty
    a_build: assert property (p_build) else $error("output frequency not controller output");
    property p_trim;
        sample_done_out && controller_function_mode_in == 3'h3 && !config_error_alarm_out
            |-> ##2 freq_out_out == $past(t_sat, 2);
    endproperty
    a_trim: assert property (p_trim) else $error("output frequency not reference plus trim");
    property p_p_only;
        sample_done_out && controller_function_mode_in != 3'h0 && integral_time_setting_in == 16'h0000
            && !config_error_alarm_out && deviation_out >= 0 |-> pi_output_out == p_sat;
    endproperty
    a_p_only: assert property (p_p_only) else $error("proportional only output wrong");
    property p_dev_done;
        $changed(deviation_out) |-> ##[1:60] sample_done_out;
    endproperty
    a_dev_done: assert property (p_dev_done) else $error("sample not completed");
    property p_rd_bad;
        reg_req_in.rd_en && !(reg_req_in.addr inside {16'h0006, 16'h000f}) |=> reg_rdata_out == 16'h0000;
    endproperty
    a_rd_bad: assert property (p_rd_bad) else $error("unmapped read not zero");
endmodule // pispc_top_chk

bind pispc_top pispc_top_chk i_chk (
    .clk_in(clk_in), .rstn_in(rstn_in), .reg_req_in(reg_req_in), .reg_rdata_out(reg_rdata_out),
    .controller_function_mode_in(controller_function_mode_in), .analog_input_one_in(analog_input_one_in),
    .analog_input_two_in(analog_input_two_in), .prop_gain_in(prop_gain_in),
    .integral_time_setting_in(integral_time_setting_in), .freq_ref_in(freq_ref_in),
    .freq_out_out(freq_out_out), .pi_output_out(pi_output_out), .deviation_out(deviation_out),
    .config_error_alarm_out(config_error_alarm_out), .diff_feedback_active_out(diff_feedback_active_out),
    .sample_done_out(sample_done_out)
);

// ===== testbench/pispc_top_tb.sv
module pispc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    pispc_pkg::pispc_reg_req_t req = '0;
    logic [2:0] mode = 3'h0;
    logic [7:0] c1 = 8'h00, c2 = 8'h00;
    logic signed [15:0] s1 = '0, s2 = '0, st_val = '0, fref = '0;
    logic st_en = 1'b0;
    logic [15:0] gain = '0, ti = '0, rdata;
    pispc_pkg::pispc_ain_t a1, a2;
    logic signed [15:0] f_out, pi_out, dev;
    logic alarm, diff_on, done;
    int n_errors = 0, num_checks = 0, cycles = 0, spw = 0, cmd = 0, isum = 0;
    // Codes of input one, input two, stored enable, command bit
    logic [17:0] cfg [8] = '{{8'h0b, 8'h00, 2'h0}, {8'h0c, 8'h0b, 2'h0}, {8'h16, 8'h0b, 2'h1},
        {8'h0b, 8'h00, 2'h2}, {8'h0c, 8'h0c, 2'h0}, {8'h0b, 8'h0b, 2'h0}, {8'h16, 8'h16, 2'h0},
        {8'h0c, 8'h00, 2'h2}};
    always #10 clk_in = ~clk_in;
    pispc_sensor_model i_sens1 (.clk_in(clk_in), .code_in(c1), .level_in(s1), .ain_out(a1));
    pispc_sensor_model i_sens2 (.clk_in(clk_in), .code_in(c2), .level_in(s2), .ain_out(a2));
    // Short sample period keeps the run brief
    pispc_top #(.SAMPLE_CYCLES(64), .SAMPLES_PER_TI_UNIT(1)) i_dut (
        .clk_in(clk_in), .rstn_in(rstn_in), .reg_req_in(req), .reg_rdata_out(rdata),
        .controller_function_mode_in(mode), .analog_input_one_in(a1), .analog_input_two_in(a2),
        .stored_setpoint_enable_in(st_en), .stored_setpoint_value_in(st_val), .prop_gain_in(gain),
        .integral_time_setting_in(ti), .freq_ref_in(fref), .freq_out_out(f_out),
        .pi_output_out(pi_out), .deviation_out(dev), .config_error_alarm_out(alarm),
        .diff_feedback_active_out(diff_on), .sample_done_out(done)
    );
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic reg_op(input logic wr, input logic [15:0] a, input logic [15:0] d);
        req = '{wr_en: wr, rd_en: !wr, addr: a, wdata: d};
        @(negedge clk_in);
        req = '0;
        @(negedge clk_in);
    endtask
    task automatic wait_done;
        int k;
        k = 0;
        while (done !== 1'b1 && k < 200) begin
            @(negedge clk_in);
            k++;
        end
        if (k == 200) begin
            n_errors++;
            finish_test();
        end
    endtask
    function automatic int sat(input int v);
        return v > 32767 ? 32767 : (v < -32767 ? -32767 : v);
    endfunction
    task automatic sample_check;
        int sp, fb, d, al, p, fe;
        sp = c1 == 8'h0c ? s1 : c2 == 8'h0c ? s2 : cmd[1] ? spw : st_en ? st_val
            : mode inside {3'h1, 3'h2} ? fref : 0;
        fb = (c1 == 8'h0b ? s1 : c2 == 8'h0b ? s2 : 0) - (c1 == 8'h16 ? s1 : c2 == 8'h16 ? s2 : 0);
        al = (c1 == c2 && c1 inside {8'h0b, 8'h0c, 8'h16}) || ((c1 == 8'h0c) + (c2 == 8'h0c) + cmd[1] + st_en > 1);
        d = sat(sp - fb);
        isum = (ti == 0 || al || mode == 0) ? 0 : isum + d;
        p = (mode == 0 || al) ? 0 : sat(((d * int'(gain)) >>> 8) + (ti == 0 ? 0 : isum / int'(ti)));
        fe = (mode == 0 || al) ? fref : mode inside {3'h1, 3'h2} ? p : sat(fref + p);
        wait_done();
        @(negedge clk_in);
        check("alarm", alarm, 16'(al));
        check("diff_active", diff_on, 16'(c1 == 8'h16 || c2 == 8'h16));
        if (mode != 0 && !al) begin
            check("deviation", dev, 16'(d));
        end
        check("pi_output", pi_out, 16'(p));
        check("freq_out", f_out, 16'(fe));
        @(negedge clk_in);
    endtask
    // ----------------------------------------
    // Timeout and main sequence
    // ----------------------------------------
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            finish_test();
        end
    end
    initial begin
        void'($urandom(17));
        repeat (4) @(negedge clk_in);
        rstn_in = 1'b1;
        reg_op(1'b0, 16'h0006, 16'h0000);
        check("setpoint_word", rdata, 16'h0000);
        reg_op(1'b0, 16'h000f, 16'h0000);
        check("cmd_sel", rdata, 16'h0000);
        reg_op(1'b1, 16'h0006, 16'h00c8);
        spw = 200;
        reg_op(1'b1, 16'h0010, 16'h0002);
        reg_op(1'b0, 16'h0006, 16'h0000);
        check("setpoint_word", rdata, 16'h00c8);
        reg_op(1'b0, 16'h0010, 16'h0000);
        check("unmapped", rdata, 16'h0000);
        wait_done();
        repeat (2) @(negedge clk_in);
        foreach (cfg[i]) begin
            for (int m = 0; m < 5; m++) begin
                reg_op(1'b1, 16'h000f, {14'h0, cfg[i][0], 1'b0});
                cmd = {cfg[i][0], 1'b0};
                {c1, c2, st_en} = cfg[i][17:1];
                mode = 3'(m);
                gain = 16'(16'h0080 + $urandom_range(16'h0300));
                s1 = 16'(int'($urandom_range(2000)) - 1000);
                s2 = 16'(int'($urandom_range(2000)) - 1000);
                st_val = 16'(int'($urandom_range(2000)) - 1000);
                fref = 16'(int'($urandom_range(2000)) - 1000);
                sample_check();
            end
        end
        // Huge gain drives both signs into the clamp
        {c1, c2, st_en, mode, gain} = {8'h0c, 8'h0b, 1'b0, 3'h3, 16'hffff};
        s2 = 16'sh0000;
        for (int v = -1; v < 2; v += 2) begin
            s1 = 16'(v * 1000);
            sample_check();
        end
        gain = 16'h0000;
        s1 = 16'sh0064;
        for (int t = 1; t < 3; t++) begin
            ti = 16'h0000;
            sample_check();
            ti = 16'(t);
            repeat (3) sample_check();
        end
        finish_test();
    end
endmodule // pispc_top_tb
